/* design/pio_ctrl.sv */
`timescale 1ns/1ps
module pio_ctrl
  import pio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [I_W-1:0] in_pin,
  input wire logic baud_sw_user,
  input wire logic motion_busy,
  input wire logic prog_done,
  output logic prog_run,
  output logic start_pulse,
  output logic resume_pulse,
  output logic hold_stop,
  output logic max_stop,
  output logic pos_lim,
  output logic neg_lim,
  output logic [I_W-1:0] gp_in,
  output logic [15:0] baud_div
);

  logic [I_W-1:0] in_q1;
  logic [I_W-1:0] in_s;
  logic run_d;
  logic sw_q1;
  logic sw_s;
  pio_pu_e pu;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic wr_q;
  logic [7:0] addr_q;
  logic cmd_run;
  logic cmd_hold;
  logic cmd_rst;
  logic rst_boot;
  logic hold;
  logic ded;
  logic clr_inact;
  logic run_rise;
  logic run_req;
  logic resume;
  logic hold_set;
  logic boot_any;
  logic pwr_run;
  logic start_req;
  logic [31:0] stat;
  logic [31:0] rd_mux;
  logic [15:0] sel_div;

  // Both flops of the input synchroniser; only the second is used below.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q1 <= '0;
      in_s <= '0;
      run_d <= 1'b0;
      sw_q1 <= 1'b0;
      sw_s <= 1'b0;
    end else begin
      in_q1 <= in_pin;
      in_s <= in_q1;
      run_d <= in_s[I_RUN];
      sw_q1 <= baud_sw_user;
      sw_s <= sw_q1;
    end
  end

  assign ded = ctrl[C_DED];
  // In dedicated mode a high clear pin means inactive, so an open pin stops the program.
  assign clr_inact = ded & in_s[I_CLR];
  assign run_rise = in_s[I_RUN] & ~run_d;
  assign run_req = ((ded & run_rise) | cmd_run) & (pu == PU_DONE);
  assign resume = run_req & hold & ~(ded & in_s[I_HOLD]) & ~clr_inact;
  assign hold_set = ((ded & in_s[I_HOLD]) | cmd_hold) & ~clr_inact;
  // A reset command repeats the boot check, so in dedicated mode a held run input restarts the program.
  assign pwr_run = boot_any & ded & in_s[I_RUN];
  assign boot_any = (pu == PU_CHECK) | rst_boot;
  assign start_req = ((run_req & ~resume) | (boot_any & ctrl[C_AUTO]) | pwr_run)
                     & ~clr_inact;

  // The power-up check waits until the synchroniser holds real samples.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pu <= PU_FILL1;
    end else begin
      case (pu)
        PU_FILL1: pu <= PU_FILL2;
        PU_FILL2: pu <= PU_CHECK;
        PU_CHECK: pu <= PU_DONE;
        default: pu <= PU_DONE;
      endcase
    end
  end

  // Address phase capture; the slave never stretches a transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    if (wr_q && addr_q == PIO_CTRL_OFS) begin
      next_ctrl = hwdata & PIO_CTRL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= PIO_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_run <= 1'b0;
      cmd_hold <= 1'b0;
      cmd_rst <= 1'b0;
      rst_boot <= 1'b0;
    end else begin
      cmd_run <= wr_q && addr_q == PIO_CMD_OFS && hwdata[K_RUN];
      cmd_hold <= wr_q && addr_q == PIO_CMD_OFS && hwdata[K_HOLD];
      cmd_rst <= wr_q && addr_q == PIO_CMD_OFS && hwdata[K_RST];
      rst_boot <= cmd_rst;
    end
  end

  // A reset command stops the program first, then restarts it a cycle later if auto start or a held dedicated run input asks.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_run <= 1'b0;
    end else if (clr_inact || prog_done || cmd_rst) begin
      prog_run <= 1'b0;
    end else if (start_req) begin
      prog_run <= 1'b1;
    end
  end

  // Setting beats a resume in the same cycle, so a fresh hold is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold <= 1'b0;
    end else if (clr_inact) begin
      hold <= 1'b0;
    end else if (hold_set) begin
      hold <= 1'b1;
    end else if (resume) begin
      hold <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pulse <= 1'b0;
      resume_pulse <= 1'b0;
      hold_stop <= 1'b0;
      max_stop <= 1'b0;
    end else begin
      start_pulse <= start_req;
      resume_pulse <= resume;
      hold_stop <= hold_set | (hold & ~resume & ~clr_inact);
      max_stop <= clr_inact & motion_busy;
    end
  end

  // Limits and general inputs follow the configuration in effect.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_lim <= 1'b0;
      neg_lim <= 1'b0;
      gp_in <= '0;
    end else begin
      pos_lim <= ctrl[C_POS_EN] & (in_s[I_POS] ^ ctrl[C_POS_POL]);
      neg_lim <= ctrl[C_NEG_EN] & (in_s[I_NEG] ^ ctrl[C_NEG_POL]);
      gp_in[I_POS] <= ~ctrl[C_POS_EN] & in_s[I_POS];
      gp_in[I_NEG] <= ~ctrl[C_NEG_EN] & in_s[I_NEG];
      gp_in[I_HOLD:I_RUN] <= ded ? 3'h0 : in_s[I_HOLD:I_RUN];
    end
  end

  always_comb begin
    case (pio_baud_e'(ctrl[C_BAUD +: 2]))
      BAUD_SEL_MID: sel_div = DIV_MID;
      BAUD_SEL_HI: sel_div = DIV_HI;
      default: sel_div = DIV_LO;
    endcase
  end

  // The stored rate is only sampled at boot, never while running.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_div <= DIV_LO;
    end else if (boot_any) begin
      baud_div <= sw_s ? sel_div : DIV_LO;
    end
  end

  always_comb begin
    stat = 32'h0000_0000;
    stat[0] = prog_run;
    stat[1] = hold;
    stat[2] = clr_inact;
    stat[3] = max_stop;
    stat[4] = pos_lim;
    stat[5] = neg_lim;
    stat[6] = sw_s;
    stat[7] = (pu == PU_DONE);
    stat[8 +: I_W] = gp_in;
  end

  // Control reads use the next value so a write just before is seen.
  always_comb begin
    if (haddr[7:0] == PIO_CTRL_OFS) begin
      rd_mux = next_ctrl;
    end else if (haddr[7:0] == PIO_STAT_OFS) begin
      rd_mux = stat;
    end else if (haddr[7:0] == PIO_BAUD_OFS) begin
      rd_mux = {16'h0000, baud_div};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  clear_stops_a: assert property (clr_inact |=> !prog_run)
    else $error("program still runs with clear inactive");
  hold_cleared_a: assert property (clr_inact |=> !hold && !hold_stop)
    else $error("hold state kept while clear inactive");
  hold_sets_a: assert property (ded && in_s[I_HOLD] && !clr_inact |=> hold)
    else $error("hold input did not set hold state");
  max_decel_a: assert property (clr_inact && motion_busy |=> max_stop)
    else $error("no maximum deceleration stop");
  resume_hold_a: assert property (resume && !hold_set |=> resume_pulse && !hold && !start_pulse)
    else $error("resume did not release hold");
  start_gate_a: assert property (start_pulse |-> $past(!clr_inact))
    else $error("start accepted while clear inactive");
  run_starts_a: assert property (start_req && !prog_done && !cmd_rst |=> prog_run)
    else $error("start request did not run program");
  limit_off_a: assert property (!ctrl[C_POS_EN] [*2] |-> !pos_lim)
    else $error("disabled limit reported active");
  baud_fixed_a: assert property (boot_any && !sw_s |=> baud_div == DIV_LO)
    else $error("fixed position did not give low rate");
  baud_late_a: assert property (!boot_any |=> $stable(baud_div))
    else $error("baud rate changed outside boot");
  pwr_block_a: assert property (boot_any && clr_inact |=> !prog_run)
    else $error("power-up start with clear inactive");
  one_pulse_a: assert property (run_rise |=> !run_rise)
    else $error("run edge seen for more than one cycle");

  // Limit and general purpose outputs follow the settings one cycle late.
  lim_pos_a: assert property (1'b1 |=> pos_lim ==
    ($past(ctrl[C_POS_EN]) && ($past(in_s[I_POS]) != $past(ctrl[C_POS_POL]))))
    else $error("positive limit does not follow its setting");

  lim_neg_a: assert property (1'b1 |=> neg_lim ==
    ($past(ctrl[C_NEG_EN]) && ($past(in_s[I_NEG]) != $past(ctrl[C_NEG_POL]))))
    else $error("negative limit does not follow its setting");

  gp_pos_a: assert property (1'b1 |=>
    gp_in[I_POS] == ($past(in_s[I_POS]) && !$past(ctrl[C_POS_EN])))
    else $error("positive input general use wrong");

  gp_neg_a: assert property (1'b1 |=>
    gp_in[I_NEG] == ($past(in_s[I_NEG]) && !$past(ctrl[C_NEG_EN])))
    else $error("negative input general use wrong");

  gp_ded_a: assert property (ded |=>
    gp_in[I_HOLD:I_RUN] == 3'h0)
    else $error("dedicated inputs shown as general");

  gp_free_a: assert property (!ded |=>
    gp_in[I_HOLD:I_RUN] == $past(in_s[I_HOLD:I_RUN]))
    else $error("general inputs not shown");

  run_cmd_a: assert property (cmd_run && pu == PU_DONE && !clr_inact && !hold
    |=> start_pulse)
    else $error("host run did not start program");

  run_edge_a: assert property (ded && run_rise && pu == PU_DONE && !clr_inact && !hold
    |=> start_pulse)
    else $error("run edge did not start program");

  held_run_a: assert property (run_req && hold && ded && in_s[I_HOLD] && !clr_inact
    |=> start_pulse && !resume_pulse)
    else $error("run with hold input active did not start");

  pwr_start_a: assert property (boot_any && ded && in_s[I_RUN] && !clr_inact
    |=> start_pulse)
    else $error("held run input did not start at boot");

  pu_order_a: assert property (pu == PU_CHECK |=>
    pu == PU_DONE)
    else $error("boot check repeated");

  max_only_a: assert property (max_stop |->
    $past(clr_inact && motion_busy))
    else $error("maximum stop without cause");

  clr_resume_a: assert property (clr_inact |=>
    !resume_pulse)
    else $error("resume accepted while clear inactive");

  clr_pulse_a: assert property (clr_inact |=>
    !start_pulse)
    else $error("start pulse while clear inactive");

  ign_cmd_a: assert property (clr_inact && (cmd_run || cmd_hold) |=>
    !start_pulse && !hold)
    else $error("host request taken while clear inactive");

  hold_decel_a: assert property (hold && !clr_inact && !resume |=>
    hold_stop)
    else $error("hold state without programmed stop");

  hold_only_a: assert property (hold_stop |->
    $past(hold || hold_set))
    else $error("programmed stop without hold state");

  resume_needs_a: assert property (resume_pulse |->
    $past(hold))
    else $error("resume without hold state");

  auto_boot_a: assert property (boot_any && ctrl[C_AUTO] && !clr_inact |=>
    start_pulse)
    else $error("auto start did not run program");

  start_cause_a: assert property (start_pulse |->
    $past(run_req || boot_any))
    else $error("start pulse without request");

  baud_user_a: assert property (boot_any && sw_s |=>
    baud_div == $past(sel_div))
    else $error("user rate not applied at boot");

  baud_legal_a: assert property (1'b1 |->
    baud_div == DIV_LO || baud_div == DIV_MID || baud_div == DIV_HI)
    else $error("baud divider holds unknown rate");

  baud_rsv_a: assert property (boot_any && sw_s && ctrl[C_BAUD +: 2] == 2'h3 |=>
    baud_div == DIV_LO)
    else $error("spare rate code not low rate");

  sync_delay_a: assert property (1'b1 |=>
    in_s == $past(in_q1))
    else $error("synchroniser stage skipped");

endmodule // pio_ctrl

/* design/pio_pkg.sv */
package pio_pkg;
  localparam logic [7:0] PIO_CTRL_OFS = 8'h00;
  localparam logic [7:0] PIO_CMD_OFS = 8'h04;
  localparam logic [7:0] PIO_STAT_OFS = 8'h08;
  localparam logic [7:0] PIO_BAUD_OFS = 8'h0C;
  // Control register fields.
  localparam int C_POS_EN = 0;
  localparam int C_NEG_EN = 1;
  localparam int C_POS_POL = 2;
  localparam int C_NEG_POL = 3;
  localparam int C_DED = 4;
  localparam int C_AUTO = 5;
  localparam int C_BAUD = 6;
  localparam logic [31:0] PIO_CTRL_MASK = 32'h0000_00FF;
  localparam logic [31:0] PIO_CTRL_RST = 32'h0000_0000;
  // Command register bits, write-one pulses.
  localparam int K_RUN = 0;
  localparam int K_HOLD = 1;
  localparam int K_RST = 2;
  // Input vector positions.
  localparam int I_POS = 0;
  localparam int I_NEG = 1;
  localparam int I_RUN = 2;
  localparam int I_CLR = 3;
  localparam int I_HOLD = 4;
  localparam int I_W = 5;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_LO = 9600;
  localparam int BAUD_MID = 19200;
  localparam int BAUD_HI = 38400;
  localparam logic [15:0] DIV_LO = 16'(CLK_HZ / BAUD_LO);
  localparam logic [15:0] DIV_MID = 16'(CLK_HZ / BAUD_MID);
  localparam logic [15:0] DIV_HI = 16'(CLK_HZ / BAUD_HI);
  typedef enum logic [1:0] {BAUD_SEL_LO, BAUD_SEL_MID, BAUD_SEL_HI, BAUD_SEL_RSV} pio_baud_e;
  typedef enum logic [1:0] {PU_FILL1, PU_FILL2, PU_CHECK, PU_DONE} pio_pu_e;
endpackage

/* testbench/pio_field_model.sv */
`timescale 1ns/1ps
module pio_field_model
  import pio_pkg::*;
(
  input wire logic [I_W-1:0] closed,
  input wire logic clr_wired,
  output logic [I_W-1:0] in_pin
);
  // A closed contact reads high, except the clear contact, which is wired the other way round.
  always_comb begin
    in_pin = closed;
    // An unwired clear contact floats up to the pull-up and so reads as clear inactive.
    in_pin[I_CLR] = clr_wired ? ~closed[I_CLR] : 1'b1;
  end
endmodule // pio_field_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pio_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, prog_run, start_pulse, resume_pulse, hold_stop, max_stop;
  logic pos_lim, neg_lim;
  logic [31:0] hrdata, rd;
  logic [I_W-1:0] in_pin, gp_in;
  logic [I_W-1:0] closed = 5'h00;
  logic clr_wired = 1'b1;
  logic baud_sw_user = 1'b0;
  logic motion_busy = 1'b0;
  logic prog_done = 1'b0;
  logic [15:0] baud_div, prev;
  logic [15:0] divs [4];
  logic [19:0] rows [6];
  int fail_count = 0, compares = 0, starts = 0, resumes = 0, cyc = 0;

  pio_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .in_pin(in_pin), .baud_sw_user(baud_sw_user),
    .motion_busy(motion_busy), .prog_done(prog_done), .prog_run(prog_run),
    .start_pulse(start_pulse), .resume_pulse(resume_pulse), .hold_stop(hold_stop),
    .max_stop(max_stop), .pos_lim(pos_lim), .neg_lim(neg_lim), .gp_in(gp_in),
    .baud_div(baud_div));
  pio_field_model field (.closed(closed), .clr_wired(clr_wired), .in_pin(in_pin));

  initial begin
    forever #5 hclk = ~hclk;
  end

  // Pulses last one cycle, so they are counted here rather than looked at by the scenarios.
  always @(posedge hclk) begin
    cyc++;
    if (start_pulse === 1'b1) starts++;
    if (resume_pulse === 1'b1) resumes++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test;
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic run_edge;
    closed[I_RUN] <= 1'b1;
    wt(4);
    closed[I_RUN] <= 1'b0;
    wt(4);
  endtask

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    divs = '{DIV_LO, DIV_MID, DIV_HI, DIV_LO};
    // Each row: control, closed contacts, expected limits {pos, neg}, expected gp_in.
    rows = '{{8'h00, 5'h03, 2'h0, 5'h0B}, {8'h03, 5'h03, 2'h3, 5'h08},
      {8'h0F, 5'h00, 2'h3, 5'h08}, {8'h1F, 5'h0B, 2'h0, 5'h00},
      {8'h05, 5'h04, 2'h2, 5'h0C}, {8'h02, 5'h02, 2'h1, 5'h08}};
    wt(6);
    hresetn <= 1'b1;
    wt(6);
    chk("baud_div", DIV_LO, baud_div);
    bus(0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      bus(1, PIO_CTRL_OFS, {24'h0, rows[i][19:12]});
      closed <= rows[i][11:7];
      wt(5);
      chk("pos_lim", rows[i][6], pos_lim);
      chk("neg_lim", rows[i][5], neg_lim);
      chk("gp_in", rows[i][4:0], gp_in);
    end
    closed <= 5'h00;
    prev = DIV_LO;
    for (int s = 0; s < 8; s++) begin
      bus(1, PIO_CTRL_OFS, {24'h0, 2'(s), 6'h00});
      baud_sw_user <= s[2];
      wt(4);
      bus(0, PIO_BAUD_OFS, 32'h0);
      chk("baud_kept", prev, rd);
      bus(1, PIO_CMD_OFS, 32'h4);
      wt(4);
      prev = s[2] ? divs[s % 4] : DIV_LO;
      chk("baud_div", prev, baud_div);
    end
    chk("no_auto", 0, starts);
    bus(1, PIO_CTRL_OFS, 32'h20);
    bus(1, PIO_CMD_OFS, 32'h4);
    wt(5);
    chk("auto_start", 1, starts);
    prog_done <= 1'b1;
    wt(2);
    prog_done <= 1'b0;
    bus(1, PIO_CMD_OFS, 32'h1);
    wt(3);
    chk("host_run", 1, prog_run);
    bus(1, PIO_CTRL_OFS, 32'h10);
    closed <= 5'h08;
    wt(5);
    run_edge;
    chk("run_edge", 3, starts);
    closed[I_HOLD] <= 1'b1;
    wt(5);
    chk("hold_set", 1, hold_stop);
    run_edge;
    chk("held_start", 4, starts);
    closed[I_HOLD] <= 1'b0;
    wt(2);
    run_edge;
    chk("resume", 1, resumes);
    chk("hold_off", 0, hold_stop);
    bus(1, PIO_CMD_OFS, 32'h2);
    wt(3);
    motion_busy <= 1'b1;
    clr_wired <= 1'b0;
    closed[I_HOLD] <= 1'b1;
    wt(5);
    chk("max_stop", 1, max_stop);
    chk("stopped", 0, prog_run);
    chk("hold_clr", 0, hold_stop);
    run_edge;
    bus(1, PIO_CMD_OFS, 32'h3);
    wt(3);
    chk("ignored", 4, starts);
    chk("hold_kept", 0, hold_stop);
    clr_wired <= 1'b1;
    motion_busy <= 1'b0;
    closed[I_HOLD] <= 1'b0;
    wt(4);
    closed[I_RUN] <= 1'b1;
    wt(5);
    chk("run_after_clr", 5, starts);
    bus(1, PIO_CMD_OFS, 32'h4);
    wt(4);
    chk("boot_run", 6, starts);
    chk("boot_prog", 1, prog_run);
    clr_wired <= 1'b0;
    wt(4);
    bus(1, PIO_CMD_OFS, 32'h4);
    wt(4);
    chk("boot_block", 6, starts);
    chk("boot_stopped", 0, prog_run);
    end_of_test;
  end
endmodule // testbench
